/* File: cvca_card_clk.sv */
`default_nettype none

// ----------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------
package cvca_pkg;

   // Reference clock and card clock range, in MHz.
   localparam int REF_MHZ      = 200;
   localparam int CARD_MHZ_MIN = 1;
   localparam int CARD_MHZ_MAX = 5;

   // Half period limits of the card clock in reference cycles.
   localparam logic [6:0] HALF_MIN = 7'(REF_MHZ / (2 * CARD_MHZ_MAX));
   localparam logic [6:0] HALF_MAX = 7'(REF_MHZ / (2 * CARD_MHZ_MIN));

   // Settle times in ns and their counts in reference cycles.
   localparam int REF_PERIOD_NS   = 1000 / REF_MHZ;
   localparam int VCC_SETTLE_NS   = 1000;
   localparam int DEACT_NS        = 1000;
   localparam logic [15:0] VCC_SETTLE_CYC =
      16'((VCC_SETTLE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
   localparam logic [15:0] DEACT_CYC =
      16'((DEACT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);

   // Card clock cycles with reset held low after the clock starts.
   localparam logic [15:0] RST_LOW_CLKS = 16'h0190;

   // Corrupted answers tolerated at one class.
   localparam logic [1:0] CORRUPT_MAX = 2'h3;

   // Class indices: bit positions in the voltage class byte.
   localparam logic [1:0] CLS_A = 2'h0;
   localparam logic [1:0] CLS_B = 2'h1;
   localparam logic [1:0] CLS_C = 2'h2;
   localparam int CLS_BITS = 3;

   // Answer-to-reset report from the receiver.
   typedef struct packed {
      logic       valid;
      logic       corrupt;
      logic       class_present;
      logic [7:0] voltage_class_byte;
   } cvca_atr_s;

   // Outcome of the sequence.
   typedef struct packed {
      logic       selected;
      logic       rejected;
      logic [1:0] class_idx;
   } cvca_status_s;

endpackage : cvca_pkg

// ----------------------------------------------------------------------
// Card clock divider
// ----------------------------------------------------------------------
module cvca_card_clk
   import cvca_pkg::*;
(
   // Clock and reset.
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   // Control.
   input  wire logic       i_run,
   input  wire logic [6:0] i_half,
   // Card clock.
   output logic            o_card_clk,
   output logic            o_rise
);

   logic [6:0] cnt_q;
   logic [6:0] half;

   // Clamp the half period so the rate stays within 1 to 5 MHz.
   always_comb
   begin
      half = i_half;
      if (i_half < HALF_MIN)
      begin
         half = HALF_MIN;
      end
      else if (i_half > HALF_MAX)
      begin
         half = HALF_MAX;
      end
   end

   // Equal high and low halves give a 50 % duty cycle.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         cnt_q      <= 7'h00;
         o_card_clk <= 1'b0;
         o_rise     <= 1'b0;
      end
      else if (i_ce)
      begin
         o_rise <= 1'b0;
         if (!i_run)
         begin
            cnt_q      <= 7'h00;
            o_card_clk <= 1'b0;
         end
         else if (cnt_q >= half - 7'h01)
         begin
            cnt_q      <= 7'h00;
            o_card_clk <= ~o_card_clk;
            o_rise     <= ~o_card_clk;
         end
         else
         begin
            cnt_q <= cnt_q + 7'h01;
         end
      end
   end

endmodule : cvca_card_clk

`default_nettype wire

/* File: cvca_top.sv */
// Contract
// - Every activation starts at the lowest-voltage class the terminal supports.
// - With no answer the card is deactivated and reactivated one class higher if supported.
// - An answer at the first class lacking that class but listing a supported one reactivates there.
// - With no common class no command is ever allowed, and the card may be deactivated.
// - A corrupted answer causes a reset at the same class until three have been seen.
// - After three corrupted answers a retry may use only the next higher class.
// - Class switching completes before any other interface activity is permitted.
// - Bits 4 and 5 mean classes D and E and are never taken as A to C.
// - The terminal generates the card clock and can run it from 1 to 5 MHz.
// - The card clock high time stays between 40 % and 60 % of the period.
// - The class field is the global byte following the T=15 indication.
`default_nettype none

module cvca_top
   import cvca_pkg::*;
#(
   parameter logic [15:0] ATR_TIMEOUT_CLKS = 16'h9c40
)
(
   // Clock, reset and enable.
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst,
   input  wire logic          i_ce,
   // Control.
   input  wire logic          i_start,
   input  wire logic [2:0]    i_term_classes,
   input  wire logic [6:0]    i_clk_half,
   // Answer report from the receiver.
   input  wire cvca_atr_s     i_atr,
   // Card pins.
   input  wire logic          i_io,
   output logic              o_io_out,
   output logic              o_io_oe,
   output logic              o_card_clk,
   output logic              o_card_rst,
   output logic              o_vcc_en,
   output logic [1:0]        o_vcc_class,
   // Status.
   output logic              o_busy,
   output logic              o_apdu_allow,
   output cvca_status_s      o_status
);

   // -------------------------------------------------------------------
   // State machine
   // -------------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE   = 7'b000_0001,
      ST_POWER  = 7'b000_0010,
      ST_CLKON  = 7'b000_0100,
      ST_WAIT   = 7'b000_1000,
      ST_DEACT  = 7'b001_0000,
      ST_DONE   = 7'b010_0000,
      ST_REJECT = 7'b100_0000
   } cvca_state_e;

   cvca_state_e state_q;
   logic [15:0] cnt_q;
   logic [1:0]  cls_q;
   logic [1:0]  corrupt_q;
   logic        first_q;
   logic        start_bit_q;
   logic        retry_q;
   logic        clk_run_q;
   logic        card_clk;
   logic        card_rise;
   logic        io_s1_q;
   logic        io_s2_q;
   logic        io_s3_q;
   logic        io_lvl_q;
   logic        io_fall;

   // Lowest voltage class the terminal supports: C before B before A.
   logic [1:0] lowest_cls;
   logic       higher_ok;
   logic [2:0] card_cls;
   logic [2:0] common;
   logic [1:0] common_low;
   logic       card_legal;

   // -------------------------------------------------------------------
   // Card clock
   // -------------------------------------------------------------------
   cvca_card_clk u_clk (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_run     (clk_run_q),
      .i_half    (i_clk_half),
      .o_card_clk(card_clk),
      .o_rise    (card_rise)
   );

   // -------------------------------------------------------------------
   // I/O pin synchroniser
   // -------------------------------------------------------------------
   // Three stages; the level changes once stages two and three agree.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         io_s1_q  <= 1'b1;
         io_s2_q  <= 1'b1;
         io_s3_q  <= 1'b1;
         io_lvl_q <= 1'b1;
      end
      else if (i_ce)
      begin
         io_s1_q <= i_io;
         io_s2_q <= io_s1_q;
         io_s3_q <= io_s2_q;
         if (io_s2_q == io_s3_q)
         begin
            io_lvl_q <= io_s3_q;
         end
      end
   end

   // A start bit is a falling edge of the filtered level.
   assign io_fall = io_lvl_q && !io_s2_q && !io_s3_q;

   // -------------------------------------------------------------------
   // Class decode
   // -------------------------------------------------------------------
   // Only bits 1 to 3 are classes A to C; D and E bits are ignored.
   always_comb
   begin
      card_cls   = i_atr.voltage_class_byte[CLS_BITS-1:0];
      card_legal = !(card_cls[CLS_A] && card_cls[CLS_C]
                     && !card_cls[CLS_B]);
      common     = card_cls & i_term_classes;
      common_low = CLS_A;
      if (common[CLS_C])
      begin
         common_low = CLS_C;
      end
      else if (common[CLS_B])
      begin
         common_low = CLS_B;
      end
      lowest_cls = CLS_A;
      if (i_term_classes[CLS_C])
      begin
         lowest_cls = CLS_C;
      end
      else if (i_term_classes[CLS_B])
      begin
         lowest_cls = CLS_B;
      end
      higher_ok = (cls_q != CLS_A) && i_term_classes[cls_q - 2'h1];
   end

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   // Walks power, clock, reset release and the answer window per class.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         state_q     <= ST_IDLE;
         cnt_q       <= 16'h0000;
         cls_q       <= CLS_A;
         corrupt_q   <= 2'h0;
         first_q     <= 1'b0;
         start_bit_q <= 1'b0;
         retry_q     <= 1'b0;
         clk_run_q   <= 1'b0;
      end
      else if (i_ce)
      begin
         unique case (state_q)
            ST_IDLE, ST_DONE, ST_REJECT:
            begin
               if (i_start && i_term_classes != 3'h0)
               begin
                  cls_q     <= lowest_cls;
                  first_q   <= 1'b1;
                  corrupt_q <= 2'h0;
                  cnt_q     <= 16'h0000;
                  clk_run_q <= 1'b0;
                  state_q   <= ST_POWER;
               end
            end
            ST_POWER:
            begin
               if (cnt_q >= VCC_SETTLE_CYC - 16'h0001)
               begin
                  cnt_q     <= 16'h0000;
                  clk_run_q <= 1'b1;
                  state_q   <= ST_CLKON;
               end
               else
               begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ST_CLKON:
            begin
               if (card_rise)
               begin
                  if (cnt_q >= RST_LOW_CLKS - 16'h0001)
                  begin
                     cnt_q       <= 16'h0000;
                     start_bit_q <= 1'b0;
                     state_q     <= ST_WAIT;
                  end
                  else
                  begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
            end
            ST_WAIT:
            begin
               if (io_fall)
               begin
                  start_bit_q <= 1'b1;
               end
               if (i_atr.valid && i_atr.corrupt)
               begin
                  cnt_q <= 16'h0000;
                  state_q <= ST_DEACT;
                  if (corrupt_q < CORRUPT_MAX - 2'h1)
                  begin
                     corrupt_q <= corrupt_q + 2'h1;
                     retry_q   <= 1'b1;
                  end
                  else
                  begin
                     corrupt_q <= 2'h0;
                     first_q   <= 1'b0;
                     retry_q   <= higher_ok;
                     cls_q     <= higher_ok ? cls_q - 2'h1 : cls_q;
                  end
               end
               else if (i_atr.valid)
               begin
                  corrupt_q <= 2'h0;
                  if (!i_atr.class_present || card_cls[cls_q])
                  begin
                     state_q <= ST_DONE;
                  end
                  else if (first_q && card_legal && common != 3'h0)
                  begin
                     cls_q   <= common_low;
                     first_q <= 1'b0;
                     retry_q <= 1'b1;
                     cnt_q   <= 16'h0000;
                     state_q <= ST_DEACT;
                  end
                  else
                  begin
                     retry_q <= 1'b0;
                     cnt_q   <= 16'h0000;
                     state_q <= ST_DEACT;
                  end
               end
               else if (card_rise && !start_bit_q)
               begin
                  if (cnt_q >= ATR_TIMEOUT_CLKS - 16'h0001)
                  begin
                     cnt_q     <= 16'h0000;
                     first_q   <= 1'b0;
                     corrupt_q <= 2'h0;
                     retry_q   <= higher_ok;
                     cls_q     <= higher_ok ? cls_q - 2'h1 : cls_q;
                     state_q   <= ST_DEACT;
                  end
                  else
                  begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
            end
            ST_DEACT:
            begin
               clk_run_q <= 1'b0;
               if (cnt_q >= DEACT_CYC - 16'h0001)
               begin
                  cnt_q   <= 16'h0000;
                  state_q <= retry_q ? ST_POWER : ST_REJECT;
               end
               else
               begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Pin and status outputs
   // -------------------------------------------------------------------
   // All outputs are registered; reset is released only in the answer
   // window and once selected, and commands are allowed only once switching has ended.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_io_out     <= 1'b0;
         o_io_oe      <= 1'b0;
         o_card_clk   <= 1'b0;
         o_card_rst   <= 1'b0;
         o_vcc_en     <= 1'b0;
         o_vcc_class  <= CLS_A;
         o_busy       <= 1'b0;
         o_apdu_allow <= 1'b0;
         o_status     <= '0;
      end
      else if (i_ce)
      begin
         o_io_out     <= 1'b0;
         o_io_oe      <= 1'b0;
         o_card_clk   <= card_clk;
         o_card_rst   <= (state_q == ST_WAIT) || (state_q == ST_DONE);
         o_vcc_en     <= (state_q == ST_POWER) || (state_q == ST_CLKON)
                         || (state_q == ST_WAIT) || (state_q == ST_DONE);
         o_vcc_class  <= cls_q;
         o_busy       <= !((state_q == ST_IDLE) || (state_q == ST_DONE)
                           || (state_q == ST_REJECT));
         o_apdu_allow <= (state_q == ST_DONE);
         o_status.selected  <= (state_q == ST_DONE);
         o_status.rejected  <= (state_q == ST_REJECT);
         o_status.class_idx <= cls_q;
      end
   end

endmodule : cvca_top

`default_nettype wire

/* File: cvca_checker.sv */
`default_nettype none
// ----------------------------------------
// Port checker for the activation sequencer
// ----------------------------------------
module cvca_checker
   import cvca_pkg::*;
#(
   parameter logic [15:0] ATR_TIMEOUT_CLKS = 16'h9c40
)
(
   // Clock and reset.
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   // Inputs of the block.
   input  wire logic [2:0]   i_term_classes,
   input  wire logic [6:0]   i_clk_half,
   input  wire cvca_atr_s    i_atr,
   input  wire logic         i_io,
   // Outputs of the block.
   input  wire logic         o_card_clk,
   input  wire logic         o_card_rst,
   input  wire logic         o_vcc_en,
   input  wire logic [1:0]   o_vcc_class,
   input  wire logic         o_busy,
   input  wire logic         o_apdu_allow,
   input  wire cvca_status_s o_status
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0]  hi_q;
   logic [6:0]  lo_q;
   logic [15:0] ris_q;
   logic        clk_q;
   logic        low_seen_q;
   logic [1:0]  last_q;
   logic [1:0]  low_idx;
   // Lowest-voltage class the terminal offers.
   assign low_idx = i_term_classes[2] ? CLS_C :
                    (i_term_classes[1] ? CLS_B : CLS_A);
   // Length of the current card clock phase in reference cycles.
   always_ff @(posedge i_ref_clk)
   begin
      hi_q <= (i_rst || !o_card_clk) ? 7'h00 : hi_q + 7'h01;
      lo_q <= (i_rst || o_card_clk) ? 7'h00 : lo_q + 7'h01;
   end
   // Card clock rises and start bit seen since reset release.
   always_ff @(posedge i_ref_clk)
   begin
      clk_q <= o_card_clk;
      if (i_rst || !o_card_rst)
      begin
         ris_q      <= 16'h0000;
         low_seen_q <= 1'b0;
      end
      else
      begin
         ris_q      <= ris_q + 16'(o_card_clk && !clk_q);
         low_seen_q <= low_seen_q || !i_io;
      end
   end
   // Class of the previous power-up within one sequence.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !o_busy)
         last_q <= 2'h3;
      else if (o_vcc_en)
         last_q <= o_vcc_class;
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   property p_first;
      $rose(o_busy) |-> o_vcc_en && o_vcc_class == low_idx;
   endproperty
   a_first: assert property (p_first)
      else $error("first power-up not at lowest class");
   property p_step;
      $rose(o_vcc_en) |-> i_term_classes[o_vcc_class]
                          && o_vcc_class <= last_q;
   endproperty
   a_step: assert property (p_step)
      else $error("power-up at a wrong class");
   property p_reject;
      o_status.rejected |-> !o_apdu_allow && !o_status.selected;
   endproperty
   a_reject: assert property (p_reject)
      else $error("commands allowed after reject");
   property p_selected;
      o_apdu_allow |-> o_status.selected && o_vcc_en && o_card_rst
                       && o_status.class_idx == o_vcc_class;
   endproperty
   a_selected: assert property (p_selected)
      else $error("selected status wrong");
   property p_accept;
      i_atr.valid && o_card_rst && o_busy && !i_atr.corrupt
         && i_atr.voltage_class_byte[o_vcc_class] |-> ##2 o_apdu_allow;
   endproperty
   a_accept: assert property (p_accept)
      else $error("answer listing current class not accepted");
   property p_high;
      $fell(o_card_clk) && o_card_rst |-> hi_q == i_clk_half;
   endproperty
   a_high: assert property (p_high)
      else $error("card clock high time wrong");
   property p_low;
      $rose(o_card_clk) && o_card_rst |-> lo_q == i_clk_half;
   endproperty
   a_low: assert property (p_low)
      else $error("card clock low time wrong");
   property p_timeout;
      o_card_rst && !low_seen_q |-> ris_q <= ATR_TIMEOUT_CLKS + 16'h0002;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("silent card not released in time");
   property p_wait;
      $fell(o_card_rst) && !low_seen_q
         |-> ris_q >= ATR_TIMEOUT_CLKS - 16'h0001;
   endproperty
   a_wait: assert property (p_wait)
      else $error("silent card dropped too early");
   property p_switch;
      o_card_rst |-> o_vcc_en && $stable(o_vcc_class);
   endproperty
   a_switch: assert property (p_switch)
      else $error("class changed with reset released");
   c_selected: cover property ($rose(o_apdu_allow));
   c_rejected: cover property ($rose(o_status.rejected));
   c_retry: cover property ($fell(o_vcc_en) && o_busy);
endmodule : cvca_checker

bind cvca_top cvca_checker #(
   .ATR_TIMEOUT_CLKS(ATR_TIMEOUT_CLKS)
) cvca_checker_inst (
   .i_ref_clk(i_ref_clk),
   .i_rst(i_rst),
   .i_term_classes(i_term_classes),
   .i_clk_half(i_clk_half),
   .i_atr(i_atr),
   .i_io(i_io),
   .o_card_clk(o_card_clk),
   .o_card_rst(o_card_rst),
   .o_vcc_en(o_vcc_en),
   .o_vcc_class(o_vcc_class),
   .o_busy(o_busy),
   .o_apdu_allow(o_apdu_allow),
   .o_status(o_status)
);
`default_nettype wire

/* File: cvca_card_model.sv */
`default_nettype none
// ----------------------------------------
// Card answering reset
// ----------------------------------------
module cvca_card_model
   import cvca_pkg::*;
(
   // Clocks and reset pin.
   input  wire logic       i_ref_clk,
   input  wire logic       i_card_clk,
   input  wire logic       i_card_rst,
   // Answer kind: 0 silent, 1 good, 2 corrupt.
   input  wire logic [1:0] i_mode,
   input  wire logic [7:0] i_class_byte,
   // Line level and answer report.
   output logic            o_io,
   output cvca_atr_s       o_atr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] mode;
   logic [7:0] cls_byte;
   // The line idles high on its pull-up; a start bit pulls it low.
   initial
   begin
      o_io  = 1'b1;
      o_atr = '0;
      forever
      begin
         @(posedge i_card_rst);
         mode     = i_mode;
         cls_byte = i_class_byte;
         if (mode != 2'h0)
         begin
            repeat (10) @(posedge i_card_clk);
            o_io = 1'b0;
            @(posedge i_card_clk);
            o_io = 1'b1;
            @(negedge i_ref_clk);
            o_atr = '{1'b1, mode == 2'h2, 1'b1, cls_byte};
            @(negedge i_ref_clk);
            o_atr = '0;
         end
      end
   end
endmodule : cvca_card_model
`default_nettype wire

/* File: cvca_top_test.sv */
`default_nettype none
// ----------------------------------------
// Testbench
// ----------------------------------------
module cvca_top_test
   import cvca_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         i_ref_clk;
   logic         i_rst;
   logic         i_start;
   logic [2:0]   i_term_classes;
   logic [6:0]   i_clk_half;
   logic [1:0]   mode;
   logic [7:0]   class_byte;
   cvca_atr_s    atr;
   logic         io;
   logic         card_clk;
   logic         card_rst;
   logic         vcc_en;
   logic         busy;
   logic         apdu_allow;
   logic         io_oe;
   logic         io_out;
   logic [1:0]   vcc_class;
   cvca_status_s status;
   int           fail_count = 0;
   int           n_tests = 0;
   int           cycles = 0;
   cvca_top #(.ATR_TIMEOUT_CLKS(16'h0032)) cvca_top_inst (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ce(1'b1),
      .i_start(i_start),
      .i_term_classes(i_term_classes),
      .i_clk_half(i_clk_half),
      .i_atr(atr),
      .i_io(io),
      .o_io_out(io_out),
      .o_io_oe(io_oe),
      .o_card_clk(card_clk),
      .o_card_rst(card_rst),
      .o_vcc_en(vcc_en),
      .o_vcc_class(vcc_class),
      .o_busy(busy),
      .o_apdu_allow(apdu_allow),
      .o_status(status)
   );
   cvca_card_model cvca_card_model_inst (
      .i_ref_clk(i_ref_clk),
      .i_card_clk(card_clk),
      .i_card_rst(card_rst),
      .i_mode(mode),
      .i_class_byte(class_byte),
      .o_io(io),
      .o_atr(atr)
   );
   // Reference clock of 5 ns.
   initial
   begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   // Prints the counts and the verdict, then stops.
   task complete_run;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   // Cuts a hung run short.
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == 110000)
      begin
         fail_count++;
         complete_run();
      end
   end
   // Compares a seen value with the expected one.
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
      end
   endtask : check
   // Starts a sequence with the given supported classes.
   task start_seq(input logic [2:0] term);
      @(negedge i_ref_clk);
      i_term_classes = term;
      i_start        = 1'b1;
      @(negedge i_ref_clk);
      i_start = 1'b0;
   endtask : start_seq
   // Waits for the next reset release and checks the class applied.
   task activation(input logic [1:0] cls);
      int n;
      n = 0;
      while (card_rst !== 1'b0 && n < 25000)
      begin
         @(negedge i_ref_clk);
         n++;
      end
      while (card_rst !== 1'b1 && n < 25000)
      begin
         @(negedge i_ref_clk);
         n++;
      end
      check({7'h00, card_rst}, 8'h01);
      check({7'h00, vcc_en}, 8'h01);
      check({6'h00, vcc_class}, {6'h00, cls});
   endtask : activation
   // Waits for the outcome and checks status and pins.
   task outcome(input logic sel, input logic [1:0] cls);
      int n;
      n = 0;
      while (status.selected !== 1'b1 && status.rejected !== 1'b1
             && n < 25000)
      begin
         @(negedge i_ref_clk);
         n++;
      end
      @(negedge i_ref_clk);
      check({6'h00, status.selected, status.rejected}, {6'h00, sel, !sel});
      check({7'h00, apdu_allow}, {7'h00, sel});
      check({7'h00, vcc_en}, {7'h00, sel});
      check({7'h00, busy}, 8'h00);
      if (sel)
         check({6'h00, status.class_idx}, {6'h00, cls});
   endtask : outcome
   // First answer lists B with the D and E bits, then the card keeps corrupting at B.
   task scen_corrupt;
      mode       = 2'h1;
      class_byte = 8'h1a;
      start_seq(3'h6);
      activation(CLS_C);
      mode = 2'h2;
      activation(CLS_B);
      activation(CLS_B);
      activation(CLS_B);
      outcome(1'b0, CLS_B);
   endtask : scen_corrupt
   // Silent card at the lowest class, then a good answer one class up.
   task scen_silent;
      mode = 2'h0;
      start_seq(3'h7);
      activation(CLS_C);
      mode       = 2'h1;
      class_byte = 8'h02;
      activation(CLS_B);
      outcome(1'b1, CLS_B);
      check({7'h00, io_oe}, 8'h00);
      check({7'h00, io_out}, 8'h00);
   endtask : scen_silent
   // Reset, then the scenarios in turn.
   initial
   begin
      i_rst          = 1'b1;
      i_start        = 1'b0;
      i_term_classes = 3'h0;
      i_clk_half     = 7'h14;
      mode           = 2'h0;
      class_byte     = 8'h00;
      repeat (4) @(negedge i_ref_clk);
      i_rst = 1'b0;
      check({7'h00, vcc_en}, 8'h00);
      scen_corrupt();
      scen_silent();
      complete_run();
   end
endmodule : cvca_top_test
`default_nettype wire
